// [bench/dox_mem_model.sv]
// Memory model of the workspace and operand words beyond the unit.
`default_nettype none
module dox_mem_model (
  input  wire logic        pclk,
  input  wire logic        we,
  input  wire logic [7:0]  wa,
  input  wire logic [15:0] wd,
  input  wire logic [7:0]  ra,
  output logic      [15:0] rd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:255];
  // Only whole words are stored, so byte merging must already be done by the unit.
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[wa] <= wd;
    end
  end
  assign rd = mem[ra];
endmodule
`default_nettype wire

// [bench/test_dual_operand_and_xop_decode.sv]
// Self-checking testbench of the dual-operand and extended-operation unit.
`include "dox_regs.svh"
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module test_dual_operand_and_xop_decode;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq = 1'b0;
  logic        int_ack;
  logic        mem_we = 1'b0;
  logic [7:0]  mem_wa = 8'h00;
  logic [15:0] mem_wd = 16'h0;
  logic [7:0]  mem_ra = 8'h00;
  logic [15:0] mem_rd;
  logic [31:0] seed = 32'hc7c25a1d;
  logic [15:0] v [1:9];
  logic [31:0] got [10:16];
  logic [31:0] q;
  logic        e;
  logic        bs;
  logic [15:0] s;
  logic [15:0] d;
  logic [15:0] n;
  logic [31:0] ex;
  logic [3:0]  sr;
  logic [3:0]  dr;
  int          op;
  int          k;
  int          ops [6] = '{5, 3, 4, 7, 2, 6};
  int          mops [5] = '{14, 14, 15, 15, 15};
  int          error_cnt = 0;
  int          num_checks = 0;

  always #20 pclk = ~pclk;

  dox_core DUT (
    .pclk                 (pclk),
    .presetn              (presetn),
    .paddr                (paddr),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .interrupt_request_in (irq),
    .interrupt_accept     (int_ack)
  );

  dox_mem_model mem (
    .pclk (pclk),
    .we   (mem_we),
    .wa   (mem_wa),
    .wd   (mem_wd),
    .ra   (mem_ra),
    .rd   (mem_rd)
  );

  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction

  function automatic logic [31:0] gen_model(input int op, input logic bs, input int sv,
                                            input logic [15:0] dw, input logic [15:0] st);
    int msk;
    int sg;
    int x;
    int r;
    logic [15:0] o;
    msk = bs ? 'hff : 'hffff;
    sg = bs ? 'h80 : 'h8000;
    x = bs ? dw[15:8] : dw;
    o = st;
    case (op)
      5: r = x + sv;
      3: r = x + (~sv & msk) + 1;
      7: r = x | sv;
      2: r = x & ~sv;
      default: r = sv;
    endcase
    if (op == 5 || op == 3) begin
      o[12] = r > msk;
      o[11] = (((sv & sg) == (x & sg)) == (op == 5)) && ((r & sg) != (x & sg));
    end
    r = r & msk;
    if (op == 4) begin
      o[15] = sv > x;
      o[14] = ((sv & sg) == 0 && (x & sg) != 0) ||
              ((sv & sg) == (x & sg) && ((x - sv) & sg) != 0);
      o[13] = sv == x;
    end else begin
      o[15] = r != 0;
      o[14] = r != 0 && (r & sg) == 0;
      o[13] = r == 0;
    end
    if (bs) o[10] = ^8'(op == 4 ? sv : r);
    return {bs ? {r[7:0], dw[7:0]} : r[15:0], o};
  endfunction

  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task run(input logic [15:0] ir);
    for (int i = 1; i < 10; i++) apb(1'b1, 8'(i * 4), {16'h0, v[i]});
    apb(1'b1, `DOX_A_INSTR, {16'h0, ir});
    for (int t = 0; t < 10; t++) begin
      apb(1'b0, `DOX_A_INFO, 32'h0);
      if (q[13] === 1'b0) break;
    end
    for (int i = 10; i < 17; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      got[i] = q;
    end
  endtask

  // The result goes through the memory so a wrong merge of the kept byte shows up.
  task wb(input logic [15:0] exp_w);
    @(posedge pclk);
    mem_we <= 1'b1;
    mem_wa <= got[14][8:1];
    mem_wd <= got[10][15:0];
    mem_ra <= got[14][8:1];
    @(posedge pclk);
    mem_we <= 1'b0;
    @(posedge pclk);
    `CHK(mem_rd, exp_w)
  endtask

  task end_of_test();
    if (error_cnt == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #2000000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 1; i < 10; i++) v[i] = rnd();
    apb(1'b0, 8'h44, 32'h0);
    `CHK({e, q}, 33'h100000000)
    apb(1'b1, `DOX_A_RES, 32'h1234);
    `CHK(e, 1'b1)
    for (k = 0; k < 24; k++) begin
      s = rnd();
      d = rnd();
      n = rnd();
      bs = n[0];
      sr = 4'(1 + n[3:1]);
      dr = 4'(9 + n[5:4]);
      op = ops[n[15:8] % 6];
      v[1] = rnd();
      v[2] = s;
      v[3] = d;
      v[5] = 16'h0100;
      v[6] = s;
      v[7] = d;
      run({3'(op), bs, 2'b00, dr, 2'b00, sr});
      ex = gen_model(op, bs, bs ? s[15:8] : s, d, v[1]);
      `CHK(got[12][15:0], ex[15:0])
      `CHK(got[16][1], op != 4)
      `CHK(got[16][10], bs)
      `CHK(got[14][15:0], 16'(16'h0100 + 2 * dr))
      if (op != 4) wb(ex[31:16]);
    end
    for (k = 0; k < 2; k++) begin
      bs = k[0];
      v[2] = 16'haa55;
      v[3] = 16'h1234;
      v[7] = 16'h1234;
      v[6] = 16'(16'h1000 + k);
      run({3'b110, bs, 2'b11, 4'd2, 2'b11, 4'd3});
      ex = gen_model(6, bs, bs ? 16'h0055 : 16'haa55, 16'h1234, v[1]);
      `CHK(got[10][15:0], ex[31:16])
      `CHK(got[15][15:0], 16'(v[6] + (bs ? 1 : 2)))
      `CHK(got[13][15:0], v[6])
      `CHK(got[14][15:0], v[7])
      `CHK(got[15][31:16], 16'(v[7] + (bs ? 1 : 2)))
    end
    v[6] = 16'h7777;
    v[7] = 16'h0010;
    v[8] = 16'h0200;
    v[9] = 16'h0300;
    run({3'b110, 1'b0, 2'b10, 4'd5, 2'b10, 4'd0});
    `CHK(got[13][15:0], 16'h0200)
    `CHK(got[14][15:0], 16'h0310)
    `CHK(got[16][5:4], 2'h2)
    for (k = 0; k < 4; k++) begin
      op = 8 + k % 2;
      v[2] = rnd() & 16'h0303;
      v[3] = rnd();
      v[7] = v[3];
      v[6] = 16'h2000;
      run({6'(op), 4'd4, 2'b11, 4'd6});
      ex = {16'h0, v[1]};
      ex[13] = op == 8 ? (v[2] & ~v[3]) == 0 : (v[2] & v[3]) == 0;
      `CHK(got[12][15:0], ex[15:0])
      `CHK(got[15][15:0], 16'h2002)
    end
    for (k = 0; k < 5; k++) begin
      op = mops[k];
      dr = k == 0 ? 4'd4 : (k == 4 ? 4'd3 : 4'd15);
      d = rnd() & 16'h7fff;
      n = rnd();
      s = k < 2 ? rnd() : 16'(d + (k == 2 ? 0 : 1 + (rnd() & 16'h00ff)));
      v[2] = s;
      v[6] = s;
      v[3] = d;
      v[7] = d;
      v[4] = n;
      run({6'(op), dr, 2'b00, 4'd1});
      ex = {d, n};
      if (op == 14) begin
        `CHK({got[10][15:0], got[11][15:0]}, 32'(d) * 32'(s))
        `CHK(got[12][15:0], v[1])
      end else if (s <= d) begin
        `CHK(got[12][15:0], v[1] | 16'h0800)
        `CHK(got[16][1], 1'b0)
      end else begin
        `CHK({got[10][15:0], got[11][15:0]}, {16'(ex / s), 16'(ex % s)})
      end
      `CHK(got[16][3], dr == 15)
    end
    irq <= 1'b1;
    @(posedge pclk);
    @(posedge pclk);
    `CHK(int_ack, 1'b1)
    v[6] = 16'h0500;
    run({6'h0b, 4'd3, 2'b01, 4'd2});
    `CHK(got[14][15:0], 16'h004c)
    `CHK(got[12][15:0], v[1] | 16'h0200)
    `CHK(got[10][15:0], 16'h0500)
    `CHK(got[11][15:0], v[1])
    `CHK(int_ack, 1'b0)
    run({3'b110, 1'b0, 2'b00, 4'd2, 2'b00, 4'd1});
    `CHK(int_ack, 1'b1)
    end_of_test();
  end
endmodule
`default_nettype wire

// [core/dox_core.sv]
// Dual-operand and extended-operation decode and execute unit behind an APB slave.
`include "dox_regs.svh"
`default_nettype none
// Operation
// - Byte bit set means byte operands at byte addresses, else words.
// - Mode 00 register, 01 indirect, 10 symbolic or indexed, 11 auto-increment.
// - Register 0 never indexes; mode 10 with register 0 is absolute.
// - Byte operand in a register uses bits 0-7, bits 8-15 kept.
// - General format auto-increment adds 1 for bytes, 2 for words.
// - Both modes 10 take two extension words, source base first.
// - General opcodes add, compare, subtract, set-ones, set-zeroes, move; bit 3 byte.
// - Add and subtract update bits 0-4, others 0-2, bytes add bit 5.
// - Compare writes nothing, updates bits 0-2 and bit 5 for bytes.
// - Register-destination format increments source pointer by 2, destination is D.
// - Compare-ones sets equal when destination has ones wherever source has.
// - Compare-zeros sets equal when destination has zeros wherever source has ones.
// - Multiply stores unsigned product high in D, low in D+1, status kept.
// - Multiply into register 15 puts the low half in the following word.
// - Divide with divisor not above destination does nothing and sets overflow.
// - Divide splits D:D+1 by source into quotient D, remainder D+1.
// - Divide at register 15 uses the following memory word as D+1.
// - Extended operation sets bit 6, vectors at 40 hex plus four D.
// - New workspace gets source address as result and old status as second result.
// - No interrupt is taken right after an extended operation completes.
// - Parity set on odd ones for bytes; interrupt mask bits never change.
// - Overflow on add and subtract follows the sign rules of operands.
module dox_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        interrupt_request_in,
  output logic             interrupt_accept
);

  function automatic logic [15:0] ea_f(input logic [1:0] m, input logic [3:0] r,
                                       input logic [15:0] rv, input logic [15:0] wp,
                                       input logic [15:0] ext);
    logic [15:0] a;
    a = rv;
    if (m == `DOX_M_REG) begin
      a = wp + {11'h000, r, 1'b0};
    end else if (m == `DOX_M_SYM) begin
      a = ext + ((r != 4'h0) ? rv : 16'h0000);
    end
    return a;
  endfunction

  // Bytes are moved to the high half so that sign, carry and zero work as for words.
  function automatic logic [15:0] bsel(input logic [15:0] w, input logic odd);
    return odd ? {w[7:0], 8'h00} : {w[15:8], 8'h00};
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] w, input logic [7:0] b,
                                        input logic odd);
    return odd ? {w[15:8], b} : {b, w[7:0]};
  endfunction

  dox_pkg::dox_regs_s q;
  dox_pkg::dox_regs_s next_q;
  dox_pkg::dox_res_s  rs;
  logic               gen;
  logic               fmt2;
  logic               bt;
  logic               both10;
  logic               cmp;
  logic               zcmp;
  logic               is_x;
  logic               hit;
  logic               ro;
  logic [1:0]         smode;
  logic [1:0]         dmode;
  logic [3:0]         sreg;
  logic [3:0]         dreg;
  logic [2:0]         op3;
  logic [5:0]         op6;
  logic [15:0]        sea;
  logic [15:0]        dea;
  logic [15:0]        so;
  logic [15:0]        dop;
  logic [15:0]        r;
  logic [15:0]        stn;
  logic [31:0]        rd;
  logic [16:0]        sum;
  logic [16:0]        dif;
  logic [31:0]        prod;
  logic [31:0]        dvd;
  logic [31:0]        quo;
  logic [31:0]        rem;

  always_comb begin
    next_q = q;
    op3    = q.ir[15:13];
    op6    = q.ir[15:10];
    dreg   = q.ir[9:6];
    dmode  = q.ir[11:10];
    smode  = q.ir[5:4];
    sreg   = q.ir[3:0];
    gen    = op3[2] | op3[1];
    fmt2   = (op3 == 3'h1);
    bt     = gen & q.ir[12];
    is_x   = fmt2 && (op6 == `DOX_OP_EXTOP);
    both10 = gen && (smode == `DOX_M_SYM) && (dmode == `DOX_M_SYM);
    sea    = ea_f(smode, sreg, q.srgv, q.wp, q.ext1);
    if (gen) begin
      dea = ea_f(dmode, dreg, q.drgv, q.wp, both10 ? q.ext2 : q.ext1);
    end else begin
      dea = ea_f(`DOX_M_REG, dreg, 16'h0000, q.wp, 16'h0000);
    end
    so   = bt ? bsel(q.srcv, sea[0]) : q.srcv;
    dop  = bt ? bsel(q.dstv, dea[0]) : q.dstv;
    sum  = {1'b0, dop} + {1'b0, so};
    dif  = {1'b0, dop} + {1'b0, ~so} + 17'h00001;
    prod = 32'(q.dstv) * 32'(q.srcv);
    dvd  = {q.dstv, q.nxtv};
    quo  = dvd / 32'(q.srcv);
    rem  = dvd % 32'(q.srcv);
    r    = 16'h0000;
    stn  = q.stin;
    cmp  = 1'b0;
    zcmp = 1'b0;
    rs         = '0;
    rs.done    = 1'b1;
    rs.byte_op = bt;
    rs.sea     = sea;
    rs.dea     = dea;
    rs.nxtmem  = fmt2 && (dreg == 4'hf);
    rs.ext     = {1'b0, smode == `DOX_M_SYM} + {1'b0, gen && (dmode == `DOX_M_SYM)};
    if (smode == `DOX_M_INC) begin
      rs.sinc = bt ? 2'h1 : 2'h2;
    end
    if (gen && (dmode == `DOX_M_INC)) begin
      rs.dinc = bt ? 2'h1 : 2'h2;
    end
    rs.sptr = q.srgv + {14'h0000, rs.sinc};
    rs.dptr = q.drgv + {14'h0000, rs.dinc};
    if (gen) begin
      rs.wr = 1'b1;
      zcmp  = 1'b1;
      case (op3)
        `DOX_OP_ADD: begin
          r              = sum[15:0];
          stn[`DOX_ST_C]  = sum[16];
          stn[`DOX_ST_OV] = (so[15] == dop[15]) && (r[15] != dop[15]);
        end
        `DOX_OP_SUB: begin
          r              = dif[15:0];
          stn[`DOX_ST_C]  = dif[16];
          stn[`DOX_ST_OV] = (so[15] != dop[15]) && (r[15] != dop[15]);
        end
        `DOX_OP_CMP: begin
          rs.wr = 1'b0;
          zcmp  = 1'b0;
          cmp   = 1'b1;
        end
        `DOX_OP_SOC: begin
          r = dop | so;
        end
        `DOX_OP_SZC: begin
          r = dop & ~so;
        end
        default: begin
          r = so;
        end
      endcase
      if (bt) begin
        stn[`DOX_ST_P] = cmp ? ^so[15:8] : ^r[15:8];
      end
    end else if (fmt2) begin
      case (op6)
        `DOX_OP_COC: begin
          stn[`DOX_ST_EQ] = ((so & ~dop) == 16'h0000);
        end
        `DOX_OP_CZC: begin
          stn[`DOX_ST_EQ] = ((so & dop) == 16'h0000);
        end
        `DOX_OP_XOR: begin
          r     = dop ^ so;
          rs.wr = 1'b1;
          zcmp  = 1'b1;
        end
        `DOX_OP_EXTOP: begin
          stn[`DOX_ST_X] = 1'b1;
          r             = sea;
          rs.res2       = q.stin;
          rs.dea        = `DOX_VEC_BASE + {10'h000, dreg, 2'b00};
        end
        `DOX_OP_MULT: begin
          r       = prod[31:16];
          rs.res2 = prod[15:0];
          rs.wr   = 1'b1;
          rs.wr2  = 1'b1;
        end
        `DOX_OP_DIVD: begin
          if (q.srcv <= q.dstv) begin
            stn[`DOX_ST_OV] = 1'b1;
          end else begin
            stn[`DOX_ST_OV] = 1'b0;
            r              = quo[15:0];
            rs.res2        = rem[15:0];
            rs.wr          = 1'b1;
            rs.wr2         = 1'b1;
          end
        end
        default: begin
          rs.bad = 1'b1;
        end
      endcase
    end else begin
      rs.bad = 1'b1;
    end
    if (zcmp) begin
      stn[`DOX_ST_LGT] = (r != 16'h0000);
      stn[`DOX_ST_AGT] = ~r[15] && (r != 16'h0000);
      stn[`DOX_ST_EQ]  = (r == 16'h0000);
    end
    if (cmp) begin
      stn[`DOX_ST_LGT] = (so[15] & ~dop[15]) | ((so[15] == dop[15]) & dif[15]);
      stn[`DOX_ST_AGT] = (~so[15] & dop[15]) | ((so[15] == dop[15]) & dif[15]);
      stn[`DOX_ST_EQ]  = (so == dop);
    end
    rs.stout = stn;
    rs.res   = (bt && rs.wr) ? merge(q.dstv, r[15:8], dea[0]) : r;
    next_q.res.done = 1'b0;
    if (q.st == dox_pkg::dox_exec) begin
      next_q.res     = rs;
      next_q.st      = dox_pkg::dox_idle;
      next_q.inhibit = is_x;
    end
    // Reads are sampled in the setup phase so that prdata comes from a flop.
    hit = 1'b1;
    ro  = 1'b0;
    rd  = 32'h00000000;
    if (paddr == `DOX_A_INSTR) begin
      rd = {16'h0000, q.ir};
    end else if (paddr == `DOX_A_STIN) begin
      rd = {16'h0000, q.stin};
    end else if (paddr == `DOX_A_SRCV) begin
      rd = {16'h0000, q.srcv};
    end else if (paddr == `DOX_A_DSTV) begin
      rd = {16'h0000, q.dstv};
    end else if (paddr == `DOX_A_NXTV) begin
      rd = {16'h0000, q.nxtv};
    end else if (paddr == `DOX_A_WP) begin
      rd = {16'h0000, q.wp};
    end else if (paddr == `DOX_A_SRGV) begin
      rd = {16'h0000, q.srgv};
    end else if (paddr == `DOX_A_DRGV) begin
      rd = {16'h0000, q.drgv};
    end else if (paddr == `DOX_A_EXT1) begin
      rd = {16'h0000, q.ext1};
    end else if (paddr == `DOX_A_EXT2) begin
      rd = {16'h0000, q.ext2};
    end else if (paddr == `DOX_A_RES) begin
      rd = {16'h0000, q.res.res};
      ro = 1'b1;
    end else if (paddr == `DOX_A_RES2) begin
      rd = {16'h0000, q.res.res2};
      ro = 1'b1;
    end else if (paddr == `DOX_A_STOUT) begin
      rd = {16'h0000, q.res.stout};
      ro = 1'b1;
    end else if (paddr == `DOX_A_SEA) begin
      rd = {16'h0000, q.res.sea};
      ro = 1'b1;
    end else if (paddr == `DOX_A_DEA) begin
      rd = {16'h0000, q.res.dea};
      ro = 1'b1;
    end else if (paddr == `DOX_A_PTR) begin
      rd = {q.res.dptr, q.res.sptr};
      ro = 1'b1;
    end else if (paddr == `DOX_A_INFO) begin
      rd = {18'h00000, q.st == dox_pkg::dox_exec, q.inhibit, q.res.bad, q.res.byte_op,
            q.res.dinc, q.res.sinc, q.res.ext, q.res.nxtmem, q.res.wr2, q.res.wr,
            q.res.done};
      ro = 1'b1;
    end else begin
      hit = 1'b0;
    end
    if (psel && !penable) begin
      next_q.rdata = pwrite ? 32'h00000000 : rd;
      next_q.err   = !hit || (pwrite && ro);
    end
    if (psel && penable && pwrite && hit && !ro) begin
      if (paddr == `DOX_A_INSTR) begin
        next_q.ir = pwdata[15:0];
        next_q.st = dox_pkg::dox_exec;
      end else if (paddr == `DOX_A_STIN) begin
        next_q.stin = pwdata[15:0];
      end else if (paddr == `DOX_A_SRCV) begin
        next_q.srcv = pwdata[15:0];
      end else if (paddr == `DOX_A_DSTV) begin
        next_q.dstv = pwdata[15:0];
      end else if (paddr == `DOX_A_NXTV) begin
        next_q.nxtv = pwdata[15:0];
      end else if (paddr == `DOX_A_WP) begin
        next_q.wp = pwdata[15:0];
      end else if (paddr == `DOX_A_SRGV) begin
        next_q.srgv = pwdata[15:0];
      end else if (paddr == `DOX_A_DRGV) begin
        next_q.drgv = pwdata[15:0];
      end else if (paddr == `DOX_A_EXT1) begin
        next_q.ext1 = pwdata[15:0];
      end else begin
        next_q.ext2 = pwdata[15:0];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign prdata  = q.rdata;
  assign pready  = psel & penable;
  assign pslverr = psel & penable & q.err;
  // Interrupts are held off while busy and for one instruction after a vector jump.
  assign interrupt_accept = interrupt_request_in && (q.st == dox_pkg::dox_idle)
                            && !q.inhibit;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence go_s;
    psel && penable && pwrite && (paddr == `DOX_A_INSTR);
  endsequence
  sequence run_s;
    (q.st == dox_pkg::dox_exec) ##1 q.res.done;
  endsequence
  exec_order_a: assert property (go_s |=> run_s)
    else $error("Instruction did not complete two cycles after the write.");
  mask_keep_a: assert property (q.res.done |-> q.res.stout[3:0] == $past(q.stin[3:0]))
    else $error("Interrupt mask changed by an instruction.");
  mult_prod_a: assert property (q.res.done && $past(q.ir[15:10]) == `DOX_OP_MULT
    && $past(q.ir[15:13]) == 3'h1 |-> {q.res.res, q.res.res2}
    == 32'($past(q.dstv)) * 32'($past(q.srcv)) && q.res.wr2)
    else $error("Product halves are wrong.");
  div_ovf_a: assert property (q.res.done && $past(q.ir[15:10]) == `DOX_OP_DIVD
    && $past(q.srcv) <= $past(q.dstv) |-> q.res.stout[`DOX_ST_OV] && !q.res.wr)
    else $error("Divide overflow not flagged.");
  vec_addr_a: assert property (q.res.done && $past(q.ir[15:10]) == `DOX_OP_EXTOP
    |-> q.res.dea == 16'h0040 + {10'h000, $past(q.ir[9:6]), 2'b00}
    && q.res.stout[`DOX_ST_X])
    else $error("Vector address or extended flag wrong.");
  int_hold_a: assert property (q.res.done && $past(q.ir[15:10]) == `DOX_OP_EXTOP
    |-> q.inhibit && !interrupt_accept)
    else $error("Interrupt taken right after an extended operation.");
  byte_inc_a: assert property (q.res.done && q.res.byte_op
    && $past(q.ir[5:4]) == `DOX_M_INC |-> q.res.sinc == 2'h1)
    else $error("Byte auto-increment is not one.");
  cmp_nowr_a: assert property (q.res.done && $past(q.ir[15:13]) == `DOX_OP_CMP
    |-> !q.res.wr)
    else $error("Compare produced a write.");
  sym_abs_a: assert property (q.res.done && $past(q.ir[5:0]) == 6'h20
    |-> q.res.sea == $past(q.ext1))
    else $error("Symbolic address used register zero.");
  r15_next_a: assert property (q.res.done && $past(q.ir[15:13]) == 3'h1
    && $past(q.ir[9:6]) == 4'hf |-> q.res.nxtmem)
    else $error("Register 15 next word not flagged.");
endmodule
`default_nettype wire

// [core/dox_pkg.sv]
// Types of the decode and execute block.
`default_nettype none
package dox_pkg;
  typedef enum logic {dox_idle, dox_exec} dox_state_e;
  typedef struct packed {
    logic [15:0] res;
    logic [15:0] res2;
    logic [15:0] stout;
    logic [15:0] sea;
    logic [15:0] dea;
    logic [15:0] sptr;
    logic [15:0] dptr;
    logic        wr;
    logic        wr2;
    logic        nxtmem;
    logic [1:0]  ext;
    logic [1:0]  sinc;
    logic [1:0]  dinc;
    logic        byte_op;
    logic        bad;
    logic        done;
  } dox_res_s;
  typedef struct packed {
    dox_state_e  st;
    logic [15:0] ir;
    logic [15:0] stin;
    logic [15:0] srcv;
    logic [15:0] dstv;
    logic [15:0] nxtv;
    logic [15:0] wp;
    logic [15:0] srgv;
    logic [15:0] drgv;
    logic [15:0] ext1;
    logic [15:0] ext2;
    logic        inhibit;
    logic [31:0] rdata;
    logic        err;
    dox_res_s    res;
  } dox_regs_s;
endpackage
`default_nettype wire

// [core/dox_regs.svh]
// Register offsets, field positions, codes and constants of the decode and execute block.
`ifndef DOX_REGS_SVH
`define DOX_REGS_SVH
`define DOX_A_INSTR  8'h00
`define DOX_A_STIN   8'h04
`define DOX_A_SRCV   8'h08
`define DOX_A_DSTV   8'h0c
`define DOX_A_NXTV   8'h10
`define DOX_A_WP     8'h14
`define DOX_A_SRGV   8'h18
`define DOX_A_DRGV   8'h1c
`define DOX_A_EXT1   8'h20
`define DOX_A_EXT2   8'h24
`define DOX_A_RES    8'h28
`define DOX_A_RES2   8'h2c
`define DOX_A_STOUT  8'h30
`define DOX_A_SEA    8'h34
`define DOX_A_DEA    8'h38
`define DOX_A_PTR    8'h3c
`define DOX_A_INFO   8'h40
`define DOX_ST_LGT   15
`define DOX_ST_AGT   14
`define DOX_ST_EQ    13
`define DOX_ST_C     12
`define DOX_ST_OV    11
`define DOX_ST_P     10
`define DOX_ST_X     9
`define DOX_M_REG    2'h0
`define DOX_M_IND    2'h1
`define DOX_M_SYM    2'h2
`define DOX_M_INC    2'h3
`define DOX_OP_ADD   3'h5
`define DOX_OP_CMP   3'h4
`define DOX_OP_SUB   3'h3
`define DOX_OP_SOC   3'h7
`define DOX_OP_SZC   3'h2
`define DOX_OP_MOVE  3'h6
`define DOX_OP_COC   6'h08
`define DOX_OP_CZC   6'h09
`define DOX_OP_XOR   6'h0a
`define DOX_OP_EXTOP 6'h0b
`define DOX_OP_MULT  6'h0e
`define DOX_OP_DIVD  6'h0f
`define DOX_VEC_BASE 16'h0040
`endif
